// *** rtl/line_mix_pkg.sv ***
// Constants and types for the line-output mixer control register slice.
// Assumes a 32-bit APB master; each register takes one aligned word at four times its index.
`default_nettype none
package line_mix_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [9:0] IDX_RIGHT_DAC_TO_LEFT_LINE_MIX       = 10'h055;
  localparam logic [9:0] IDX_LEFT_LINE_OUTPUT_LEVEL           = 10'h056;
  localparam logic [9:0] IDX_LEFT_LINE2_TO_RIGHT_LINE_MIX     = 10'h057;
  localparam logic [9:0] IDX_LEFT_INPUT_AMP_TO_RIGHT_LINE_MIX = 10'h058;
  localparam logic [9:0] IDX_LEFT_DAC_TO_RIGHT_LINE_MIX       = 10'h059;
  localparam logic [9:0] IDX_RIGHT_LINE2_TO_RIGHT_LINE_MIX    = 10'h05A;

  localparam int MIX_COUNT = 5;

  // Entry 0 feeds the left line output, entries 1 to 4 feed the right line output.
  localparam logic [4:0][9:0] MIX_INDEX = {
    IDX_RIGHT_LINE2_TO_RIGHT_LINE_MIX,
    IDX_LEFT_DAC_TO_RIGHT_LINE_MIX,
    IDX_LEFT_INPUT_AMP_TO_RIGHT_LINE_MIX,
    IDX_LEFT_LINE2_TO_RIGHT_LINE_MIX,
    IDX_RIGHT_DAC_TO_LEFT_LINE_MIX
  };

  // Field positions of the left line output stage register.
  localparam int LEVEL_MSB   = 7;
  localparam int LEVEL_LSB   = 4;
  localparam int UNMUTE_BIT  = 3;
  localparam int RESERVED_BIT = 2;
  localparam int PENDING_BIT = 1;
  localparam int POWER_BIT   = 0;

  // Values after reset.
  localparam logic [3:0] LEVEL_RESET   = 4'h0;
  localparam logic       UNMUTE_RESET  = 1'b0;
  localparam logic       PENDING_RESET = 1'b1;
  localparam logic       POWER_RESET   = 1'b0;
  localparam logic [7:0] MIX_RESET     = 8'h00;

  typedef struct packed {
    logic       route;
    logic [6:0] atten;
  } path_type;

  typedef struct packed {
    logic [3:0] level;
    logic       unmute;
  } stage_type;

endpackage : line_mix_pkg

`default_nettype wire

// *** rtl/line_mix_regs.sv ***
// APB register slice controlling the line-output mixers and the left line output stage.
// Assumes the analog side drives the pending and power status levels asynchronously.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RULE_01] Bit 7 of 0x55 routes right DAC left.
// [RULE_02] Bits 6-0 of mixer registers: attenuation code.
// [RULE_03] Bit 7 of 0x57 routes left line2 right.
// [RULE_04] Bit 7 of 0x58 routes left amp right.
// [RULE_05] Bit 7 of 0x59 routes left DAC right.
// [RULE_06] Bit 7 of 0x5a routes right line2 right.
// [RULE_07] Bits 7-4 of 0x56: level, 1 dB steps.
// [RULE_08] Software never writes level codes 1010 to 1111.
// [RULE_09] Bit 3 of 0x56: zero mutes, one unmutes.
// [RULE_10] Bit 2 of 0x56 reserved, reads zero.
// [RULE_11] Bit 1 of 0x56 shows gain still pending.
// [RULE_12] Bit 0 of 0x56 shows output powered up.
// [RULE_13] Writes to read-only bits are ignored.
module line_mix_regs
#(
  parameter int ADDR_WIDTH = 12
)
(
  input  wire logic                                       pclk,           // APB clock, 250 MHz
  input  wire logic                                       presetn,        // Async reset, low
  input  wire logic                                       psel,           // APB select
  input  wire logic                                       penable,        // APB access phase
  input  wire logic                                       pwrite,         // APB write
  input  wire logic [ADDR_WIDTH-1:0]                      paddr,          // APB byte address
  input  wire logic [31:0]                                pwdata,         // APB write data
  input  wire logic [3:0]                                 pstrb,          // APB byte strobes
  output logic      [31:0]                                prdata,         // APB read data
  output logic                                            pready,         // APB ready
  output logic                                            pslverr,        // APB error
  input  wire logic                                       gain_pending,   // Analog gain ramp busy
  input  wire logic                                       left_power_up,  // Left output powered
  output line_mix_pkg::path_type [line_mix_pkg::MIX_COUNT-1:0] mix_path,  // Mixer routes
  output line_mix_pkg::stage_type                          left_stage      // Left stage level
);

  logic [31:0]              prdata_reg;
  logic [31:0]              prdata_next;
  logic                     pready_reg;
  logic                     pready_next;
  logic                     pslverr_reg;
  logic                     pslverr_next;
  logic [3:0]               level_reg;
  logic [3:0]               level_next;
  logic                     unmute_reg;
  logic                     unmute_next;
  logic                     pending_meta_reg;
  logic                     pending_sync_reg;
  logic                     power_meta_reg;
  logic                     power_sync_reg;
  logic [9:0]               index;
  logic                     mapped;
  logic                     wr_fire;
  // Unpacked so that each generate branch owns its own element outright.
  line_mix_pkg::path_type   mix_reg [line_mix_pkg::MIX_COUNT];
  line_mix_pkg::path_type   mix_next [line_mix_pkg::MIX_COUNT];

  assign index = 10'(paddr[ADDR_WIDTH-1:2]);

  always_comb
  begin
    mapped = (paddr[1:0] == 2'h0)
             && (index >= line_mix_pkg::IDX_RIGHT_DAC_TO_LEFT_LINE_MIX)
             && (index <= line_mix_pkg::IDX_RIGHT_LINE2_TO_RIGHT_LINE_MIX);
  end

  // A write lands only at the edge where the master sees pready high.
  assign wr_fire = psel && penable && pready_reg && pwrite && mapped && pstrb[0];

  // Mixer path registers: every bit is writable.
  genvar i;
  generate
    for (i = 0; i < line_mix_pkg::MIX_COUNT; i++)
    begin : g_mix
      always_comb
      begin
        mix_next[i] = mix_reg[i];
        if (wr_fire && (index == line_mix_pkg::MIX_INDEX[i]))
        begin
          mix_next[i] = line_mix_pkg::path_type'(pwdata[7:0]); // see [RULE_01] see [RULE_02] see [RULE_03] see [RULE_04] see [RULE_05] see [RULE_06]
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mix_reg[i] <= line_mix_pkg::path_type'(line_mix_pkg::MIX_RESET);
        end
        else
        begin
          mix_reg[i] <= mix_next[i];
        end
      end
    end
  endgenerate

  // Output stage register; status bits are never taken from the bus.
  always_comb
  begin
    level_next  = level_reg;
    unmute_next = unmute_reg;
    if (wr_fire && (index == line_mix_pkg::IDX_LEFT_LINE_OUTPUT_LEVEL))
    begin
      // Codes above nine are left to software to avoid; they are stored as written.
      level_next  = pwdata[line_mix_pkg::LEVEL_MSB:line_mix_pkg::LEVEL_LSB]; // see [RULE_07] see [RULE_08]
      unmute_next = pwdata[line_mix_pkg::UNMUTE_BIT];                        // see [RULE_09] see [RULE_13]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_reg  <= line_mix_pkg::LEVEL_RESET;
      unmute_reg <= line_mix_pkg::UNMUTE_RESET;
    end
    else
    begin
      level_reg  <= level_next;
      unmute_reg <= unmute_next;
    end
  end

  // Two-stage synchronisers; the pending pair resets high so the bit reads one after reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_meta_reg <= line_mix_pkg::PENDING_RESET;
      pending_sync_reg <= line_mix_pkg::PENDING_RESET; // see [RULE_11]
      power_meta_reg   <= line_mix_pkg::POWER_RESET;
      power_sync_reg   <= line_mix_pkg::POWER_RESET;   // see [RULE_12]
    end
    else
    begin
      pending_meta_reg <= gain_pending;
      pending_sync_reg <= pending_meta_reg;
      power_meta_reg   <= left_power_up;
      power_sync_reg   <= power_meta_reg;
    end
  end

  // One wait state: pready rises in the second access cycle, with the read data.
  always_comb
  begin
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (psel && penable && !pready_reg)
    begin
      pready_next  = 1'b1;
      pslverr_next = !mapped;
      prdata_next  = 32'h0000_0000;
      if (!pwrite && mapped)
      begin
        if (index == line_mix_pkg::IDX_LEFT_LINE_OUTPUT_LEVEL)
        begin
          prdata_next[line_mix_pkg::LEVEL_MSB:line_mix_pkg::LEVEL_LSB] = level_reg;
          prdata_next[line_mix_pkg::UNMUTE_BIT]  = unmute_reg;
          prdata_next[line_mix_pkg::RESERVED_BIT] = 1'b0;            // see [RULE_10]
          prdata_next[line_mix_pkg::PENDING_BIT] = pending_sync_reg; // see [RULE_11]
          prdata_next[line_mix_pkg::POWER_BIT]   = power_sync_reg;   // see [RULE_12]
        end
        else
        begin
          for (int k = 0; k < line_mix_pkg::MIX_COUNT; k++)
          begin
            if (index == line_mix_pkg::MIX_INDEX[k])
            begin
              prdata_next[7:0] = mix_reg[k];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign left_stage        = '{level: level_reg, unmute: unmute_reg};

  always_comb
  begin
    for (int m = 0; m < line_mix_pkg::MIX_COUNT; m++)
    begin
      mix_path[m] = mix_reg[m];
    end
  end

endmodule : line_mix_regs

`default_nettype wire

// *** verif/line_mix_regs_properties.sv ***
// Concurrent checks for the line-output mixer register slice.
// Assumes it is bound to line_mix_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module line_mix_regs_properties
#(
  parameter int ADDR_WIDTH = 12
)
(
  input wire logic                    pclk,       // Clock
  input wire logic                    presetn,    // Reset, low
  input wire logic                    psel,       // Select
  input wire logic                    penable,    // Access
  input wire logic                    pwrite,     // Write
  input wire logic [ADDR_WIDTH-1:0]   paddr,      // Address
  input wire logic [31:0]             pwdata,     // Write data
  input wire logic [3:0]              pstrb,      // Strobes
  input wire logic [31:0]             prdata,     // Read data
  input wire logic                    pready,     // Ready
  input wire line_mix_pkg::path_type [line_mix_pkg::MIX_COUNT-1:0] mix_path, // Routes
  input wire line_mix_pkg::stage_type left_stage  // Stage
);
  logic            wa;
  logic [9:0]      idx;
  logic [7:0]      wd;
  // Only aligned, byte-0 writes may commit; anything else must leave state alone.
  assign wa = psel && penable && pready && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  assign idx = paddr[ADDR_WIDTH-1:2];
  assign wd = pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_route_rdac: assert property (wa && idx == 10'h055 |=> mix_path[0] == $past(wd))
    else $error("path 0 not loaded");
  a_route_lline: assert property (wa && idx == 10'h057 |=> mix_path[1] == $past(wd))
    else $error("path 1 not loaded");
  a_route_lamp: assert property (wa && idx == 10'h058 |=> mix_path[2] == $past(wd))
    else $error("path 2 not loaded");
  a_route_ldac: assert property (wa && idx == 10'h059 |=> mix_path[3] == $past(wd))
    else $error("path 3 not loaded");
  a_route_rline: assert property (wa && idx == 10'h05A |=> mix_path[4] == $past(wd))
    else $error("path 4 not loaded");
  a_stage_load: assert property (wa && idx == 10'h056 |=> left_stage == $past(wd[7:3]))
    else $error("stage not loaded");
  a_stage_hold: assert property (!(wa && idx == 10'h056) |=> $stable(left_stage))
    else $error("stage changed without write");
  a_reserved_zero: assert property (pready && !pwrite && idx == 10'h056 |-> !prdata[2])
    else $error("reserved bit not zero");
endmodule : line_mix_regs_properties
bind line_mix_regs line_mix_regs_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .mix_path(mix_path), .left_stage(left_stage));
`default_nettype wire

// *** verif/line_mix_regs_tb.sv ***
// Self-checking bench for the line-output mixer register slice over APB.
// Assumes the checker file binds its assertions into the design.
`timescale 1ns/100ps
`default_nettype none
module line_mix_regs_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, got_err;
  logic        gain_pending, left_power_up;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, got;
  logic [7:0]  v;
  logic [3:0]  pstrb;
  int          err_count, comparisons;
  line_mix_pkg::path_type [4:0] mix_path;
  line_mix_pkg::stage_type      left_stage;
  line_mix_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gain_pending(gain_pending),
    .left_power_up(left_power_up), .mix_path(mix_path), .left_stage(left_stage));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // One APB transfer; read data and error are taken at the edge where pready is seen.
  task automatic apb_xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                          input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    got = prdata;
    got_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    gain_pending = 1'b1;
    left_power_up = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb_xfer(1'b0, 12'h154 + 12'(4 * i), '0, 4'hF);
      check(got, i == 1 ? 32'h2 : 32'h0);
      check(got_err, 1'b0);
    end
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < 2; j++)
      begin
        a = k == 0 ? 12'h154 : 12'h158 + 12'(4 * k);
        v = j == 0 ? 8'h81 + 8'(k) : 8'h7F - 8'(k);
        apb_xfer(1'b1, a, {24'hFFFFFF, v}, 4'hF);
        apb_xfer(1'b0, a, '0, 4'hF);
        check(got, {24'h0, v});
        check(mix_path[k], v);
      end
    apb_xfer(1'b1, 12'h154, 32'h0, 4'hE);
    apb_xfer(1'b0, 12'h154, '0, 4'hF);
    check(got, 32'h7F);
    check(mix_path[0], 8'h7F);
    // Status inputs move each pass so the read-only bits must follow them, not the write.
    for (int l = 0; l < 10; l++)
    begin
      gain_pending <= l[0];
      left_power_up <= ~l[0];
      // Levels stay within 0 to 9 and the reserved bit is written as zero.
      apb_xfer(1'b1, 12'h158, {24'h0, 4'(l), l[1], 3'b011}, 4'hF);
      apb_xfer(1'b0, 12'h158, '0, 4'hF);
      check(got, {24'h0, 4'(l), l[1], 1'b0, l[0], ~l[0]});
      check(left_stage, {4'(l), l[1]});
    end
    apb_xfer(1'b1, 12'h150, 32'hFF, 4'hF);
    check(got_err, 1'b1);
    apb_xfer(1'b0, 12'h155, '0, 4'hF);
    check(got, 32'h0);
    check(got_err, 1'b1);
    print_verdict();
  end
  initial
  begin
    #20000;
    err_count++;
    print_verdict();
  end
endmodule : line_mix_regs_tb
`default_nettype wire
